// ---- src/scpeq_conflict.sv ----
// setting conflict checks between requested and current operating modes
`timescale 1ns/1ns
module scpeq_conflict
  import scpeq_pkg::*;
(
  input wire logic [31:0] timing, // requested timing percents
  input wire logic [31:0] level, // requested amplitude and offset
  input wire logic [5:0] cur_mode, // mode now in force
  input wire logic [5:0] new_mode, // requested mode
  output logic timing_bad, // timing sum too large
  output logic level_bad, // level too large
  output logic mode_bad // mode combination refused
);
  // ----------------------------------------------------------------
  // timing and level limits
  // ----------------------------------------------------------------
  wire [9:0] pct_sum = {2'b00, timing[7:0]} + {2'b00, timing[15:8]} + {2'b00, timing[23:16]};
  wire signed [16:0] off = {level[31], level[31:16]};
  wire [16:0] off_abs = off[16] ? 17'(-off) : 17'(off);
  wire [17:0] lvl_sum = {3'b000, level[15:1]} + {1'b0, off_abs};
  assign timing_bad = pct_sum > 10'(PCT_MAX);
  assign level_bad = lvl_sum > 18'(LEVEL_MAX_MV);

  // ----------------------------------------------------------------
  // mode combinations; advance mode judged as currently set
  // ----------------------------------------------------------------
  wire filt_sine = new_mode[MODE_FILT_BIT] && new_mode[MODE_SINE_BIT];
  wire burst_seq = new_mode[MODE_BURST_BIT] && new_mode[MODE_SEQ_BIT];
  wire trig_off = cur_mode[MODE_TRIG_BIT] && !new_mode[MODE_TRIG_BIT];
  wire trig_on = !cur_mode[MODE_TRIG_BIT] && new_mode[MODE_TRIG_BIT];
  wire adv_bad = (trig_off && !cur_mode[MODE_AUTO_BIT])
              || (trig_on && cur_mode[MODE_AUTO_BIT]);
  assign mode_bad = filt_sine || burst_seq || adv_bad;
endmodule

// ---- src/scpeq_err_fifo.sv ----
// bounded oldest-first error queue with overflow replacement and lock
`timescale 1ns/1ns
module scpeq_err_fifo
  import scpeq_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk, // block clock
  input wire logic rst_n, // async reset, low
  input wire logic clr, // empty the queue
  input wire logic push, // new error event
  input wire scpeq_kind_t push_kind, // kind of the new error
  input wire logic pop, // remove oldest entry
  output scpeq_kind_t head_kind, // oldest entry
  output logic empty, // queue holds nothing
  output logic [CW-1:0] count, // entries held
  output logic lock // overflow lock active
);
  localparam int PW = $clog2(DEPTH);

  scpeq_kind_t mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] count_reg, count_next;
  logic lock_reg, lock_next;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // push, pop and overflow decisions
  // ----------------------------------------------------------------
  wire full = (count_reg == CW'(DEPTH));
  wire do_pop = pop && (count_reg != '0);
  wire do_push = push && !lock_reg && !clr;
  wire do_store = do_push && (!full || do_pop);
  wire do_ovf = do_push && full && !do_pop;
  wire [PW-1:0] last_ptr = (wr_ptr_reg == '0) ? PW'(DEPTH - 1) : wr_ptr_reg - 1'b1;

  // next state; a read frees the slot and drops the lock
  always_comb begin
    if (clr) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next = '0;
      lock_next = 1'b0;
    end else begin
      wr_ptr_next = do_store ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
      rd_ptr_next = do_pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
      count_next = count_reg + CW'(do_store) - CW'(do_pop);
      lock_next = do_ovf ? 1'b1 : (do_pop ? 1'b0 : lock_reg);
    end
  end

  // pointer state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      lock_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      lock_reg <= lock_next;
    end
  end

  // storage has no reset; the pointers decide what is valid
  always_ff @(posedge clk) begin
    if (do_store) begin
      mem[wr_ptr_reg] <= push_kind;
    end else if (do_ovf) begin
      mem[last_ptr] <= KIND_QUEUE_OVF;
    end
  end

  assign head_kind = mem[rd_ptr_reg];
  assign empty = (count_reg == '0);
  assign count = count_reg;
  assign lock = lock_reg;
endmodule

// ---- src/scpeq_pkg.sv ----
// package: offsets, fields, limits and error codes of the error queue block
package scpeq_pkg;

  // ----------------------------------------------------------------
  // queue and checking limits
  // ----------------------------------------------------------------
  localparam int QUEUE_DEPTH = 30;
  localparam int MSG_MAX_LEN = 80;
  localparam int PCT_MAX = 100;
  localparam int LEVEL_MAX_MV = 16000;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_ERR_POST = 6'h04;
  localparam logic [5:0] OFS_ERR_QUERY = 6'h08;
  localparam logic [5:0] OFS_STATUS = 6'h0C;
  localparam logic [5:0] OFS_ESR = 6'h10;
  localparam logic [5:0] OFS_TIMING = 6'h14;
  localparam logic [5:0] OFS_LEVEL = 6'h18;
  localparam logic [5:0] OFS_MODE = 6'h1C;
  localparam logic [5:0] OFS_QUERY = 6'h20;
  localparam logic [5:0] OFS_OUTBUF = 6'h24;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CLS_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int CTRL_DCL_BIT = 2;
  localparam int ESR_QYE_BIT = 2;
  localparam int ESR_DDE_BIT = 3;
  localparam int ESR_EXE_BIT = 4;
  localparam int ESR_CME_BIT = 5;
  localparam int MODE_FILT_BIT = 0;
  localparam int MODE_SINE_BIT = 1;
  localparam int MODE_BURST_BIT = 2;
  localparam int MODE_SEQ_BIT = 3;
  localparam int MODE_TRIG_BIT = 4;
  localparam int MODE_AUTO_BIT = 5;
  localparam int STAT_LOCK_BIT = 8;
  localparam int STAT_MAV_BIT = 9;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] MODE_RESET = 6'h00;
  localparam logic [31:0] TIMING_RESET = 32'h0000_0000;
  localparam logic [31:0] LEVEL_RESET = 32'h0000_03E8;
  localparam logic [7:0] ESR_RESET = 8'h00;

  // error kinds held in the queue; the host maps each to its message
  typedef enum logic [4:0] {
    KIND_NONE = 5'h00, KIND_CMD = 5'h01, KIND_CHAR = 5'h02,
    KIND_SYNTAX = 5'h03, KIND_SEP = 5'h04, KIND_DTYPE = 5'h05,
    KIND_PARM_EXTRA = 5'h06, KIND_PARM_MISS = 5'h07, KIND_NUM_NA = 5'h08,
    KIND_SUFFIX = 5'h09, KIND_CHDATA_NA = 5'h0A, KIND_EXEC = 5'h0B,
    KIND_CONFLICT = 5'h0C, KIND_RANGE = 5'h0D, KIND_ILLEGAL = 5'h0E,
    KIND_DEVICE = 5'h0F, KIND_MEMORY = 5'h10, KIND_QUEUE_OVF = 5'h11,
    KIND_INTERRUPTED = 5'h12
  } scpeq_kind_t;

  // signed 16-bit code returned for each kind
  function automatic logic [15:0] scpeq_code(input scpeq_kind_t k);
    case (k)
      KIND_NONE: return 16'h0000;
      KIND_CMD: return 16'hFF9C;
      KIND_CHAR: return 16'hFF9B;
      KIND_SYNTAX: return 16'hFF9A;
      KIND_SEP: return 16'hFF99;
      KIND_DTYPE: return 16'hFF98;
      KIND_PARM_EXTRA: return 16'hFF94;
      KIND_PARM_MISS: return 16'hFF93;
      KIND_NUM_NA: return 16'hFF80;
      KIND_SUFFIX: return 16'hFF7D;
      KIND_CHDATA_NA: return 16'hFF6C;
      KIND_EXEC: return 16'hFF38;
      KIND_CONFLICT: return 16'hFF23;
      KIND_RANGE: return 16'hFF22;
      KIND_ILLEGAL: return 16'hFF20;
      KIND_DEVICE: return 16'hFED4;
      KIND_MEMORY: return 16'hFEC9;
      KIND_QUEUE_OVF: return 16'hFEA2;
      KIND_INTERRUPTED: return 16'hFE66;
      default: return 16'hFF9C;
    endcase
  endfunction

endpackage

// ---- src/scpeq_top.sv ----
// error queue, output buffer and setting checks of the command interpreter
// ----------------------------------------------------------------
// Summary of operation
// - an invalid command posts an error entry without any host request
// - each error query removes and returns exactly one entry
// - entries come back oldest first
// - an empty queue answers code 0, no error
// - a 31st error overwrites the newest entry with -350
// - after overflow all errors are dropped until one entry is read
// - reset and clear-status empty the queue
// - the reset command leaves the queue untouched
// - an entry is a signed code plus a message of up to 80 characters
// - command errors -100 to -104 by syntax fault
// - -108 too many parameters, -109 missing parameter
// - -128 numeric, -131 suffix, -148 character data not allowed
// - -222 out of range, -224 illegal discrete value
// - pulse or ramp timing over 100 percent gives -221
// - half amplitude plus absolute offset over 16 V gives -221
// - filter with built-in sine gives -221
// - burst with sequence gives -221
// - trigger mode change against sequence advance gives -221
// - -200 execution, -300 device, -311 memory fault
// - query into an occupied output buffer gives -410, old data kept
// - reset and device clear empty the output buffer
// - command errors also set event status bit 5
// ----------------------------------------------------------------
`timescale 1ns/1ns
module scpeq_top
  import scpeq_pkg::*;
(
  input wire logic MCLK, // 10 MHz block clock
  input wire logic RESETN, // async reset, active low
  input wire logic [5:0] AVS_ADDRESS, // byte address
  input wire logic AVS_READ, // read request
  input wire logic AVS_WRITE, // write request
  input wire logic [31:0] AVS_WRITEDATA, // write data
  input wire logic [3:0] AVS_BYTEENABLE, // byte lanes
  output logic [31:0] AVS_READDATA, // read data, registered
  output logic AVS_WAITREQUEST, // stall until answered
  output logic ERR_PENDING, // error queue not empty
  output logic MAV // output buffer holds a response
);
  localparam int CW = $clog2(QUEUE_DEPTH + 1);

  // ----------------------------------------------------------------
  // bus handshake: every access takes two cycles
  // ----------------------------------------------------------------
  logic ack_reg;
  logic [31:0] rdata_reg, rdata_next;
  logic rd_ok_reg, rd_ok_next;
  wire req = AVS_READ || AVS_WRITE;
  wire rd_acc = AVS_READ && ack_reg;
  wire wr_acc = AVS_WRITE && ack_reg;

  // address decode
  wire sel_ctrl = (AVS_ADDRESS == OFS_CTRL);
  wire sel_post = (AVS_ADDRESS == OFS_ERR_POST);
  wire sel_equery = (AVS_ADDRESS == OFS_ERR_QUERY);
  wire sel_status = (AVS_ADDRESS == OFS_STATUS);
  wire sel_esr = (AVS_ADDRESS == OFS_ESR);
  wire sel_timing = (AVS_ADDRESS == OFS_TIMING);
  wire sel_level = (AVS_ADDRESS == OFS_LEVEL);
  wire sel_mode = (AVS_ADDRESS == OFS_MODE);
  wire sel_query = (AVS_ADDRESS == OFS_QUERY);
  wire sel_outbuf = (AVS_ADDRESS == OFS_OUTBUF);

  // byte-lane merge for the setting registers
  wire [31:0] be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                         {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  logic [5:0] mode_reg, mode_next;
  logic [31:0] timing_reg, timing_next;
  logic [31:0] level_reg, level_next;
  logic [7:0] esr_reg, esr_next;
  logic [31:0] ob_data_reg, ob_data_next;
  logic ob_valid_reg, ob_valid_next;

  wire [31:0] timing_req = (timing_reg & ~be_mask) | (AVS_WRITEDATA & be_mask);
  wire [31:0] level_req = (level_reg & ~be_mask) | (AVS_WRITEDATA & be_mask);
  wire [31:0] mode_word = ({26'h000_0000, mode_reg} & ~be_mask) | (AVS_WRITEDATA & be_mask);
  wire [5:0] mode_req = mode_word[5:0];

  // ----------------------------------------------------------------
  // commands carried by writes
  // ----------------------------------------------------------------
  wire wr_ctrl = wr_acc && sel_ctrl;
  wire do_cls = wr_ctrl && AVS_WRITEDATA[CTRL_CLS_BIT];
  wire do_rst = wr_ctrl && AVS_WRITEDATA[CTRL_RST_BIT];
  wire do_dcl = wr_ctrl && AVS_WRITEDATA[CTRL_DCL_BIT];

  // setting checks
  logic timing_bad, level_bad, mode_bad;
  scpeq_conflict u_conflict (
    .timing(timing_req),
    .level(level_req),
    .cur_mode(mode_reg),
    .new_mode(mode_req),
    .timing_bad(timing_bad),
    .level_bad(level_bad),
    .mode_bad(mode_bad)
  );
  wire wr_timing = wr_acc && sel_timing;
  wire wr_level = wr_acc && sel_level;
  wire wr_mode = wr_acc && sel_mode;
  wire conflict = (wr_timing && timing_bad) || (wr_level && level_bad)
               || (wr_mode && mode_bad);

  // queries aimed at the output buffer
  wire wr_query = wr_acc && sel_query;
  wire query_intr = wr_query && ob_valid_reg;
  wire rd_outbuf = rd_acc && sel_outbuf;

  // error posted by the parser or the execution logic; zero means none
  wire [4:0] post_raw = AVS_WRITEDATA[4:0];
  wire post_known = (post_raw <= KIND_INTERRUPTED);
  wire scpeq_kind_t post_kind = post_known ? scpeq_kind_t'(post_raw) : KIND_CMD;
  wire wr_post = wr_acc && sel_post && (post_raw != 5'h00);

  // one error source per access, so the sources never collide
  wire push = wr_post || conflict || query_intr;
  wire scpeq_kind_t push_kind = conflict ? KIND_CONFLICT
                              : (query_intr ? KIND_INTERRUPTED : post_kind);
  wire [15:0] push_code = scpeq_code(push_kind);
  wire signed [15:0] push_scode = $signed(push_code);
  wire cls_cmd = push && (push_scode <= -16'sd100) && (push_scode > -16'sd200);
  wire cls_exe = push && (push_scode <= -16'sd200) && (push_scode > -16'sd300);
  wire cls_dde = push && (push_scode <= -16'sd300);

  // ----------------------------------------------------------------
  // error queue
  // ----------------------------------------------------------------
  scpeq_kind_t head_kind;
  logic q_empty, q_lock;
  logic [CW-1:0] q_count;
  wire pop_err = rd_acc && sel_equery && rd_ok_reg;
  scpeq_err_fifo #(
    .DEPTH(QUEUE_DEPTH),
    .CW(CW)
  ) u_fifo (
    .clk(MCLK),
    .rst_n(RESETN),
    .clr(do_cls),
    .push(push),
    .push_kind(push_kind),
    .pop(pop_err),
    .head_kind(head_kind),
    .empty(q_empty),
    .count(q_count),
    .lock(q_lock)
  );

  // ----------------------------------------------------------------
  // read mux, latched at the first cycle of an access
  // ----------------------------------------------------------------
  // entry word: code in the low half, message number above it
  wire [31:0] entry_word = q_empty ? 32'h0000_0000
    : {11'h000, head_kind, scpeq_code(head_kind)};
  wire [31:0] status_word = {22'h00_0000, ob_valid_reg, q_lock, 3'b000, q_count};

  always_comb begin
    rdata_next = 32'h0000_0000;
    rd_ok_next = 1'b0;
    if (sel_equery) begin
      rdata_next = entry_word;
      rd_ok_next = !q_empty;
    end else if (sel_status) begin
      rdata_next = status_word;
    end else if (sel_esr) begin
      rdata_next = {24'h00_0000, esr_reg};
    end else if (sel_timing) begin
      rdata_next = timing_reg;
    end else if (sel_level) begin
      rdata_next = level_reg;
    end else if (sel_mode) begin
      rdata_next = {26'h000_0000, mode_reg};
    end else if (sel_outbuf) begin
      rdata_next = ob_valid_reg ? ob_data_reg : 32'h0000_0000;
      rd_ok_next = ob_valid_reg;
    end
  end

  // ----------------------------------------------------------------
  // settings: refused on conflict, restored by the reset command
  // ----------------------------------------------------------------
  always_comb begin
    timing_next = timing_reg;
    level_next = level_reg;
    mode_next = mode_reg;
    if (do_rst) begin
      timing_next = TIMING_RESET;
      level_next = LEVEL_RESET;
      mode_next = MODE_RESET;
    end else if (wr_timing && !timing_bad) begin
      timing_next = timing_req;
    end else if (wr_level && !level_bad) begin
      level_next = level_req;
    end else if (wr_mode && !mode_bad) begin
      mode_next = mode_req;
    end
  end

  // event status: set wins over the destructive read and clear-status
  wire esr_clr = do_cls || (rd_acc && sel_esr);
  wire qye_set = rd_outbuf && !rd_ok_reg;
  wire [7:0] esr_set = ({7'h00, cls_cmd} << ESR_CME_BIT)
                     | ({7'h00, cls_exe} << ESR_EXE_BIT)
                     | ({7'h00, cls_dde} << ESR_DDE_BIT)
                     | ({7'h00, qye_set} << ESR_QYE_BIT);
  assign esr_next = (esr_clr ? ESR_RESET : esr_reg) | esr_set;

  // output buffer: one response, never overwritten while unread
  always_comb begin
    ob_data_next = ob_data_reg;
    ob_valid_next = ob_valid_reg;
    if (do_dcl || do_cls) begin
      ob_valid_next = 1'b0;
    end else if (wr_query && !ob_valid_reg) begin
      ob_data_next = AVS_WRITEDATA;
      ob_valid_next = 1'b1;
    end else if (rd_outbuf && rd_ok_reg) begin
      ob_valid_next = 1'b0;
    end
  end

  // bus state
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rd_ok_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
      if (AVS_READ && !ack_reg) begin
        rdata_reg <= rdata_next;
        rd_ok_reg <= rd_ok_next;
      end
    end
  end

  // block state; power-up empties both buffers
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_reg <= MODE_RESET;
      timing_reg <= TIMING_RESET;
      level_reg <= LEVEL_RESET;
      esr_reg <= ESR_RESET;
      ob_data_reg <= 32'h0000_0000;
      ob_valid_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      timing_reg <= timing_next;
      level_reg <= level_next;
      esr_reg <= esr_next;
      ob_data_reg <= ob_data_next;
      ob_valid_reg <= ob_valid_next;
    end
  end

  assign AVS_WAITREQUEST = req && !ack_reg;
  assign AVS_READDATA = rdata_reg;
  assign ERR_PENDING = !q_empty;
  assign MAV = ob_valid_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_POP_ONE: assert property (@(posedge MCLK) disable iff (!RESETN)
    pop_err |=> q_count == $past(q_count) - CW'(1))
    else $error("error query did not remove one entry");

  AST_EMPTY_NOERR: assert property (@(posedge MCLK) disable iff (!RESETN)
    (rd_acc && sel_equery && !rd_ok_reg) |-> AVS_READDATA == 32'h0000_0000)
    else $error("empty queue did not answer no error");

  AST_OVF_LOCK: assert property (@(posedge MCLK) disable iff (!RESETN)
    (push && !q_lock && !do_cls && q_count == CW'(QUEUE_DEPTH))
    |=> q_lock && q_count == CW'(QUEUE_DEPTH))
    else $error("overflow did not lock a full queue");

  AST_DISCARD: assert property (@(posedge MCLK) disable iff (!RESETN)
    (q_lock && push && !do_cls) |=> $stable(q_count) && q_lock)
    else $error("error stored while queue locked");

  AST_CLS_EMPTY: assert property (@(posedge MCLK) disable iff (!RESETN)
    do_cls |=> q_empty && !q_lock && !MAV && esr_reg == ESR_RESET)
    else $error("clear-status left queue entries");

  AST_RST_KEEP: assert property (@(posedge MCLK) disable iff (!RESETN)
    (do_rst && !do_cls) |=> $stable(q_count) && mode_reg == MODE_RESET)
    else $error("reset command changed the queue");

  AST_CME_SET: assert property (@(posedge MCLK) disable iff (!RESETN)
    cls_cmd |=> esr_reg[ESR_CME_BIT])
    else $error("command error did not set event bit");

  AST_KEEP_RESP: assert property (@(posedge MCLK) disable iff (!RESETN)
    (query_intr && !do_cls) |=> $stable(ob_data_reg) && ob_valid_reg && !q_empty)
    else $error("occupied output buffer was overwritten");

  AST_DCL_EMPTY: assert property (@(posedge MCLK) disable iff (!RESETN)
    do_dcl |=> !MAV)
    else $error("device clear left a response");

  AST_TIMING_HOLD: assert property (@(posedge MCLK) disable iff (!RESETN)
    (wr_timing && timing_bad) |=> $stable(timing_reg) && !q_empty)
    else $error("conflicting timing was applied");

  AST_ANSWER: assert property (@(posedge MCLK) disable iff (!RESETN)
    (req && !ack_reg) |-> AVS_WAITREQUEST ##1 (!req || !AVS_WAITREQUEST))
    else $error("bus access not answered in two cycles");

  AST_POST_STORE: assert property (@(posedge MCLK) disable iff (!RESETN)
    (wr_post && !q_lock && q_count != CW'(QUEUE_DEPTH)) |=> q_count == $past(q_count) + CW'(1))
    else $error("posted error was not stored");

  AST_UNLOCK: assert property (@(posedge MCLK) disable iff (!RESETN)
    (pop_err && q_lock) |=> !q_lock && q_count == CW'(QUEUE_DEPTH - 1))
    else $error("reading an entry did not release the lock");

  AST_ENTRY_CODE: assert property (@(posedge MCLK) disable iff (!RESETN)
    (rd_acc && sel_equery && rd_ok_reg) |-> AVS_READDATA[15] && AVS_READDATA[31:21] == 11'h000)
    else $error("queue entry is not a negative code");

  AST_EXE_SET: assert property (@(posedge MCLK) disable iff (!RESETN)
    cls_exe |=> esr_reg[ESR_EXE_BIT])
    else $error("execution error did not set event bit");

  AST_DDE_SET: assert property (@(posedge MCLK) disable iff (!RESETN)
    cls_dde |=> esr_reg[ESR_DDE_BIT])
    else $error("device error did not set event bit");

  AST_LEVEL_HOLD: assert property (@(posedge MCLK) disable iff (!RESETN)
    (wr_level && level_bad) |=> $stable(level_reg) && !q_empty)
    else $error("conflicting level was applied");

  AST_MODE_HOLD: assert property (@(posedge MCLK) disable iff (!RESETN)
    (wr_mode && mode_bad) |=> $stable(mode_reg) && !q_empty)
    else $error("conflicting mode was applied");
endmodule

// ---- verif/scpeq_host_model.sv ----
// remote controller model: avalon-mm master issuing register accesses
`timescale 1ns/1ns
module scpeq_host_model (
  input wire logic clk, // block clock
  input wire logic waitrequest, // slave stall
  input wire logic [31:0] readdata, // slave read data
  output logic [5:0] address, // byte address
  output logic read, // read request
  output logic write, // write request
  output logic [31:0] writedata, // write data
  output logic [3:0] byteenable // all lanes on
);
  initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
  end

  // one access: request held until waitrequest is seen low at an edge
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= rd;
    write <= !rd;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule

// ---- verif/scpeq_top_bench.sv ----
// self-checking bench of the error queue block
`timescale 1ns/1ns
module scpeq_top_bench;
  import scpeq_pkg::*;
  logic mclk, resetn, rd_v, wr_v, wait_v, pend, mav;
  logic [5:0] adr;
  logic [31:0] wd, rdat, q;
  logic [3:0] be;
  int miscompares = 0, checks_done = 0, cyc = 0;
  int codes [18] = '{-100, -101, -102, -103, -104, -108, -109, -128, -131, -148,
    -200, -221, -222, -224, -300, -311, -350, -410};
  logic [5:0] t_adr [8] = '{OFS_MODE, OFS_MODE, OFS_TIMING, OFS_TIMING, OFS_LEVEL,
    OFS_LEVEL, OFS_MODE, OFS_MODE};
  logic [31:0] t_dat [8] = '{32'h0000_0003, 32'h0000_000C, 32'h0001_3232, 32'h0000_3232,
    32'h3E81_0000, 32'h3E80_0000, 32'h0000_0020, 32'h0000_0030};
  bit t_bad [8] = '{1, 1, 1, 0, 1, 0, 0, 1};

  scpeq_top scpeq_top_i (.MCLK(mclk), .RESETN(resetn), .AVS_ADDRESS(adr), .AVS_READ(rd_v),
    .AVS_WRITE(wr_v), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wait_v), .ERR_PENDING(pend), .MAV(mav));
  scpeq_host_model scpeq_host_model_i (.clk(mclk), .waitrequest(wait_v), .readdata(rdat),
    .address(adr), .read(rd_v), .write(wr_v), .writedata(wd), .byteenable(be));

  function automatic logic [31:0] ent(int k);
    logic [15:0] c;
    c = 16'(codes[k-1]);
    return {11'h000, 5'(k), c};
  endfunction
  task automatic wr(logic [5:0] a, logic [31:0] d);
    scpeq_host_model_i.xfer(1'b0, a, d, q);
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(string n, logic [5:0] a, logic [31:0] e);
    scpeq_host_model_i.xfer(1'b1, a, 32'h0000_0000, q);
    chk(n, e, q);
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // 10 mhz clock; a hang is cut after a generous cycle ceiling
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    resetn = 1'b0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    rdc("empty", OFS_ERR_QUERY, 32'h0000_0000);
    for (int k = 1; k <= 18; k++) wr(OFS_ERR_POST, 32'(k));
    chk("pend", 32'h1, {31'h0, pend});
    rdc("esr", OFS_ESR, 32'h0000_0038);
    for (int k = 1; k <= 18; k++) rdc("code", OFS_ERR_QUERY, ent(k));
    // overflow: 31 errors, then a dropped one, then a read frees the lock
    for (int i = 0; i < 31; i++) wr(OFS_ERR_POST, 32'h0000_0002);
    wr(OFS_ERR_POST, 32'h0000_0003);
    rdc("lock", OFS_STATUS, 32'h0000_011E);
    rdc("first", OFS_ERR_QUERY, ent(2));
    wr(OFS_ERR_POST, 32'h0000_0004);
    rdc("unlock", OFS_STATUS, 32'h0000_001E);
    for (int i = 0; i < 28; i++) rdc("fill", OFS_ERR_QUERY, ent(2));
    rdc("ovf", OFS_ERR_QUERY, ent(17));
    rdc("late", OFS_ERR_QUERY, ent(4));
    rdc("drained", OFS_ERR_QUERY, 32'h0000_0000);
    chk("idle", 32'h0, {31'h0, pend});
    // reset command keeps the queue, clear-status empties it
    wr(OFS_ERR_POST, 32'h0000_0005);
    wr(OFS_CTRL, 32'h0000_0002);
    rdc("keep", OFS_STATUS, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0001);
    rdc("cls", OFS_STATUS, 32'h0000_0000);
    // setting conflicts and their boundaries
    for (int i = 0; i < 8; i++) begin
      wr(t_adr[i], t_dat[i]);
      rdc("conflict", OFS_ERR_QUERY, t_bad[i] ? ent(12) : 32'h0);
    end
    rdc("mode", OFS_MODE, 32'h0000_0020);
    // occupied output buffer, then device clear
    wr(OFS_QUERY, 32'h0000_00AA);
    wr(OFS_QUERY, 32'h0000_00BB);
    rdc("busy", OFS_ERR_QUERY, ent(18));
    rdc("kept", OFS_OUTBUF, 32'h0000_00AA);
    wr(OFS_QUERY, 32'h0000_00CC);
    wr(OFS_CTRL, 32'h0000_0004);
    @(posedge mclk);
    chk("mav", 32'h0, {31'h0, mav});
    rdc("dcl", OFS_OUTBUF, 32'h0000_0000);
    rdc("esr2", OFS_ESR, 32'h0000_001C);
    // kind 0 is no error; an unknown kind posts the generic command error
    wr(OFS_ERR_POST, 32'h0000_0000);
    wr(OFS_ERR_POST, 32'h0000_001F);
    rdc("generic", OFS_ERR_QUERY, ent(1));
    rdc("none", OFS_ERR_QUERY, 32'h0000_0000);
    // power-up in mid-run empties the queue and the output buffer
    wr(OFS_ERR_POST, 32'h0000_0001);
    wr(OFS_QUERY, 32'h0000_0055);
    @(posedge mclk);
    chk("mav_on", 32'h1, {31'h0, mav});
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rdc("power", OFS_STATUS, 32'h0000_0000);
    report_and_stop();
  end
endmodule
